// ==== core/capture_compare_pkg.sv ====
// constants, register map and state types of the capture/compare unit
// assumes a single 25 MHz clock and an Avalon-MM register master
package capture_compare_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 16;
	localparam int TW     = 16;
	localparam int IRQ_W  = 18;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_TA_COUNT   = 8'h04;
	localparam logic [7:0] OFS_TA_RELOAD  = 8'h08;
	localparam logic [7:0] OFS_TB_COUNT   = 8'h0C;
	localparam logic [7:0] OFS_TB_RELOAD  = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h1C;
	localparam logic [1:0] BANK_CH_CFG    = 2'h1;
	localparam logic [1:0] BANK_CH_VAL    = 2'h2;

	// ----------------------------------------------------------------
	// field positions and codes
	// ----------------------------------------------------------------
	localparam int CTRL_RUN_A     = 0;
	localparam int CTRL_RUN_B     = 1;
	localparam int CTRL_STAGGER   = 2;
	localparam int CTRL_CSEL_A    = 4;
	localparam int CTRL_CSEL_B    = 8;
	localparam int IRQ_TA_OVF     = 16;
	localparam int IRQ_TB_OVF     = 17;

	localparam logic [2:0] CSEL_T6   = 3'h5;
	localparam logic [2:0] CSEL_EXT  = 3'h6;
	localparam logic [2:0] STAG_LAST = 3'h7;
	localparam logic [TW-1:0] CNT_TOP = 16'hFFFF;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [NUM_CH-1:0] ARMED_RST = 16'hFFFF;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMP_IRQ_MULTI = 2'h0,
		CMP_TOGGLE    = 2'h1,
		CMP_IRQ_ONCE  = 2'h2,
		CMP_SET_CLR   = 2'h3
	} cmp_mode_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

	typedef struct packed {
		logic      on;
		logic      dbl;
		logic      single;
		cmp_mode_t mode;
		logic      fall;
		logic      rise;
		logic      tsel;
		logic      compare;
	} chan_cfg_t;

	typedef struct packed {
		bus_state_t                   bus;
		logic [31:0]                  rdata;
		logic [2:0]                   stag;
		logic [3:0]                   pre;
		logic [1:0]                   run;
		logic                         stagger;
		logic [1:0][2:0]              csel;
		logic [1:0][TW-1:0]           cnt;
		logic [1:0][TW-1:0]           rld;
		logic [1:0]                   upd;
		logic [1:0]                   ovf;
		chan_cfg_t [NUM_CH-1:0]       cfg;
		logic [NUM_CH-1:0][TW-1:0]    val;
		logic [NUM_CH-1:0]            armed;
		logic [NUM_CH-1:0]            se_done;
		logic [NUM_CH-1:0]            pin;
		logic [NUM_CH-1:0]            oe;
		logic [NUM_CH-1:0]            s1;
		logic [NUM_CH-1:0]            s2;
		logic [NUM_CH-1:0]            s3;
		logic [NUM_CH-1:0]            lvl;
		logic [2:0]                   ext_s;
		logic                         ext_lvl;
		logic [IRQ_W-1:0]             sts;
		logic [IRQ_W-1:0]             en;
	} state_t;

endpackage

// ==== core/capture_compare_unit.sv ====
// capture/compare unit: two reloadable time bases and sixteen channels
// assumes an Avalon-MM master on CLK and asynchronous channel pins
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - sixteen channels resolve one clock normally and eight clocks when staggered.
// - two independent 16-bit time bases each have their own reload register.
// - each time base counts prescaled clock ticks or sixth-timer overflow pulses.
// - an external count input can clock a time base.
// - every channel register picks its time base and capture or compare on its own.
// - each channel owns one pin, an input in capture and an output in compare modes 1 and 3 and in double-register mode; partner pins stay undriven.
// - a capture loads the assigned timer count on the chosen pin event.
// - each capture raises that channel's own interrupt request.
// - the capture edge is rising, falling or both per channel.
// - compare channels are matched against their timer in the cycle after each count step.
// - mode 0 raises an interrupt on every match and leaves the pin alone.
// - mode 1 toggles the pin on every match.
// - mode 2 raises at most one interrupt per timer period.
// - mode 3 sets the pin on match and clears it on timer overflow, once per period.
// - in double-register mode two compare channels toggle one shared pin.
// - a single-event option limits a compare channel to one match; captures are not limited.
module capture_compare_unit
	import capture_compare_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              ARST_N,
	input  wire logic [7:0]        ADDRESS,
	input  wire logic              READ,
	input  wire logic              WRITE,
	input  wire logic [31:0]       WRITEDATA,
	input  wire logic [3:0]        BYTEENABLE,
	output logic [31:0]            READDATA,
	output logic                   WAITREQUEST,
	input  wire logic [NUM_CH-1:0] CC_IN,
	output logic [NUM_CH-1:0]      CC_OUT,
	output logic [NUM_CH-1:0]      CC_OE,
	input  wire logic              SIXTH_TIMER_OFL,
	input  wire logic              EXT_COUNT_IN,
	output logic                   IRQ
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old_w,
	                                      input logic [31:0] new_w,
	                                      input logic [3:0]  be);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic tick_of(input logic [2:0] sel,
	                                 input logic       base,
	                                 input logic [3:0] pre,
	                                 input logic       t6,
	                                 input logic       ext);
		logic r;
		r = 1'b0;
		case (sel)
			3'h0: r = base;
			3'h1: r = base && pre[0];
			3'h2: r = base && (&pre[1:0]);
			3'h3: r = base && (&pre[2:0]);
			3'h4: r = base && (&pre);
			CSEL_T6: r = t6;
			CSEL_EXT: r = ext;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_t q;
	state_t d;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			q       <= '0;
			q.bus   <= BUS_IDLE;
			q.armed <= ARMED_RST;
		end else begin
			q <= d;
		end
	end

	assign READDATA    = q.rdata;
	assign WAITREQUEST = (READ || WRITE) && (q.bus != BUS_ACK);
	assign CC_OUT      = q.pin;
	assign CC_OE       = q.oe;
	assign IRQ         = |(q.sts & q.en);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic              base;
		logic              ext_rise;
		logic              tick;
		logic              stable;
		logic              rise;
		logic              fall;
		logic              t;
		logic              match;
		logic              armed_now;
		logic              fire;
		logic              wr;
		logic [3:0]        idx;
		logic [31:0]       w;
		logic [IRQ_W-1:0]  set;
		logic [IRQ_W-1:0]  clr;
		logic [NUM_CH-1:0] tog;
		logic [NUM_CH-1:0] pset;
		logic [NUM_CH-1:0] pclr;
		logic [NUM_CH-1:0] shared;
		chan_cfg_t         c;
		base      = 1'b0;
		ext_rise  = 1'b0;
		tick      = 1'b0;
		stable    = 1'b0;
		rise      = 1'b0;
		fall      = 1'b0;
		t         = 1'b0;
		match     = 1'b0;
		armed_now = 1'b0;
		fire      = 1'b0;
		wr        = 1'b0;
		idx       = ADDRESS[5:2];
		w         = 32'h0000_0000;
		set       = '0;
		clr       = '0;
		tog       = '0;
		pset      = '0;
		pclr      = '0;
		shared    = '0;
		c         = '0;
		d         = q;

		// ------------------------------------------------------------
		// input synchronisers
		// ------------------------------------------------------------
		d.s1    = CC_IN;
		d.s2    = q.s1;
		d.s3    = q.s2;
		d.ext_s = {q.ext_s[1:0], EXT_COUNT_IN};
		if ((q.ext_s[1] == q.ext_s[2]) && (q.ext_s[2] != q.ext_lvl)) begin
			d.ext_lvl = q.ext_s[2];
			ext_rise  = q.ext_s[2];
		end

		// ------------------------------------------------------------
		// prescaler and time bases
		// ------------------------------------------------------------
		base   = !q.stagger || (q.stag == STAG_LAST);
		d.stag = 3'(q.stag + 3'h1);
		if (base) begin
			d.pre = 4'(q.pre + 4'h1);
		end
		for (int k = 0; k < 2; k++) begin
			tick = q.run[k] && tick_of(q.csel[k], base, q.pre,
			                           SIXTH_TIMER_OFL, ext_rise);
			d.upd[k] = tick;
			d.ovf[k] = 1'b0;
			if (tick) begin
				if (q.cnt[k] == CNT_TOP) begin
					d.cnt[k] = q.rld[k];
					d.ovf[k] = 1'b1;
				end else begin
					d.cnt[k] = TW'(q.cnt[k] + 16'h0001);
				end
			end
		end
		set[IRQ_TA_OVF] = q.ovf[0];
		set[IRQ_TB_OVF] = q.ovf[1];

		// ------------------------------------------------------------
		// channels
		// ------------------------------------------------------------
		for (int i = 0; i < NUM_CH / 2; i++) begin
			shared[i + NUM_CH / 2] = q.cfg[i].dbl;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			c      = q.cfg[i];
			t      = c.tsel;
			stable = (q.s2[i] == q.s3[i]) && (q.s3[i] != q.lvl[i]);
			rise   = stable && q.s3[i];
			fall   = stable && !q.s3[i];
			if (stable) begin
				d.lvl[i] = q.s3[i];
			end
			if (c.on && !c.compare && ((rise && c.rise) || (fall && c.fall))) begin
				d.val[i] = q.cnt[t];
				set[i]   = 1'b1;
			end
			armed_now = q.armed[i] || q.ovf[t];
			match = c.on && c.compare && q.upd[t] && (q.cnt[t] == q.val[i]) && !q.se_done[i];
			fire  = 1'b0;
			if (match) begin
				if (shared[i]) begin
					fire = 1'b1;
					tog[i - NUM_CH / 2] = 1'b1;
				end else if (c.dbl && (i < NUM_CH / 2)) begin
					fire   = 1'b1;
					tog[i] = 1'b1;
				end else begin
					case (c.mode)
						CMP_IRQ_MULTI: fire = 1'b1;
						CMP_TOGGLE: begin
							fire   = 1'b1;
							tog[i] = 1'b1;
						end
						CMP_IRQ_ONCE: fire = armed_now;
						CMP_SET_CLR: begin
							fire    = armed_now;
							pset[i] = armed_now;
						end
						default: fire = 1'b0;
					endcase
				end
			end
			if (c.on && c.compare && (c.mode == CMP_SET_CLR) && q.ovf[t] && !shared[i]
			    && !(c.dbl && (i < NUM_CH / 2))) begin
				pclr[i] = 1'b1;
			end
			d.armed[i] = armed_now && !fire;
			if (fire) begin
				set[i] = 1'b1;
				if (c.single) begin
					d.se_done[i] = 1'b1;
				end
			end
			d.oe[i] = c.on && c.compare && !shared[i]
			          && ((c.mode == CMP_TOGGLE) || (c.mode == CMP_SET_CLR)
			              || (c.dbl && (i < NUM_CH / 2)));
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (pset[i]) begin
				d.pin[i] = 1'b1;
			end else if (pclr[i]) begin
				d.pin[i] = 1'b0;
			end else if (tog[i]) begin
				d.pin[i] = !q.pin[i];
			end
		end

		// ------------------------------------------------------------
		// register bus
		// ------------------------------------------------------------
		case (q.bus)
			BUS_IDLE: begin
				if (READ || WRITE) begin
					d.bus = BUS_ACK;
				end
				d.rdata = 32'h0000_0000;
				if (ADDRESS == OFS_CTRL) begin
					d.rdata[CTRL_RUN_A]       = q.run[0];
					d.rdata[CTRL_RUN_B]       = q.run[1];
					d.rdata[CTRL_STAGGER]     = q.stagger;
					d.rdata[CTRL_CSEL_A +: 3] = q.csel[0];
					d.rdata[CTRL_CSEL_B +: 3] = q.csel[1];
				end else if (ADDRESS == OFS_TA_COUNT) begin
					d.rdata[TW-1:0] = q.cnt[0];
				end else if (ADDRESS == OFS_TA_RELOAD) begin
					d.rdata[TW-1:0] = q.rld[0];
				end else if (ADDRESS == OFS_TB_COUNT) begin
					d.rdata[TW-1:0] = q.cnt[1];
				end else if (ADDRESS == OFS_TB_RELOAD) begin
					d.rdata[TW-1:0] = q.rld[1];
				end else if (ADDRESS == OFS_IRQ_STATUS) begin
					d.rdata[IRQ_W-1:0] = q.sts;
				end else if (ADDRESS == OFS_IRQ_EN) begin
					d.rdata[IRQ_W-1:0] = q.en;
				end else if (ADDRESS[7:6] == BANK_CH_CFG) begin
					d.rdata[$bits(chan_cfg_t)-1:0] = q.cfg[idx];
				end else if (ADDRESS[7:6] == BANK_CH_VAL) begin
					d.rdata[TW-1:0] = q.val[idx];
				end
			end
			BUS_ACK: d.bus = BUS_IDLE;
			default: d.bus = BUS_IDLE;
		endcase
		wr = WRITE && (q.bus == BUS_ACK);
		if (wr) begin
			if (ADDRESS == OFS_CTRL) begin
				w = merge({20'h0_0000, 1'b0, q.csel[1], 1'b0, q.csel[0], 1'b0, q.stagger, q.run},
				          WRITEDATA, BYTEENABLE);
				d.run[0]  = w[CTRL_RUN_A];
				d.run[1]  = w[CTRL_RUN_B];
				d.stagger = w[CTRL_STAGGER];
				d.csel[0] = w[CTRL_CSEL_A +: 3];
				d.csel[1] = w[CTRL_CSEL_B +: 3];
			end else if (ADDRESS == OFS_TA_COUNT) begin
				w = merge({16'h0000, q.cnt[0]}, WRITEDATA, BYTEENABLE);
				d.cnt[0] = w[TW-1:0];
			end else if (ADDRESS == OFS_TA_RELOAD) begin
				w = merge({16'h0000, q.rld[0]}, WRITEDATA, BYTEENABLE);
				d.rld[0] = w[TW-1:0];
			end else if (ADDRESS == OFS_TB_COUNT) begin
				w = merge({16'h0000, q.cnt[1]}, WRITEDATA, BYTEENABLE);
				d.cnt[1] = w[TW-1:0];
			end else if (ADDRESS == OFS_TB_RELOAD) begin
				w = merge({16'h0000, q.rld[1]}, WRITEDATA, BYTEENABLE);
				d.rld[1] = w[TW-1:0];
			end else if (ADDRESS == OFS_IRQ_EN) begin
				w = merge({14'h0000, q.en}, WRITEDATA, BYTEENABLE);
				d.en = w[IRQ_W-1:0];
			end else if (ADDRESS == OFS_IRQ_CLEAR) begin
				w = merge(32'h0000_0000, WRITEDATA, BYTEENABLE);
				clr = w[IRQ_W-1:0];
			end else if (ADDRESS[7:6] == BANK_CH_CFG) begin
				w = merge({23'h00_0000, q.cfg[idx]}, WRITEDATA, BYTEENABLE);
				d.cfg[idx]     = chan_cfg_t'(w[$bits(chan_cfg_t)-1:0]);
				d.se_done[idx] = 1'b0;
				d.armed[idx]   = 1'b1;
			end else if (ADDRESS[7:6] == BANK_CH_VAL) begin
				w = merge({16'h0000, q.val[idx]}, WRITEDATA, BYTEENABLE);
				d.val[idx] = w[TW-1:0];
			end
		end

		// sticky status: a new event wins over a clear in the same cycle
		d.sts = (q.sts & ~clr) | set;
	end

endmodule

`default_nettype wire

// ==== test/capture_compare_monitor.sv ====
// checker: bus timing, pin ownership, output enables and interrupt masking
// assumes binding to capture_compare_unit, one clock domain
`timescale 1ns/10ps
`default_nettype none
module capture_compare_monitor
	import capture_compare_pkg::*;
(
	input wire logic              CLK,
	input wire logic              ARST_N,
	input wire logic [7:0]        ADDRESS,
	input wire logic              READ,
	input wire logic              WRITE,
	input wire logic [31:0]       WRITEDATA,
	input wire logic [3:0]        BYTEENABLE,
	input wire logic [31:0]       READDATA,
	input wire logic              WAITREQUEST,
	input wire logic [NUM_CH-1:0] CC_IN,
	input wire logic [NUM_CH-1:0] CC_OUT,
	input wire logic [NUM_CH-1:0] CC_OE,
	input wire logic              SIXTH_TIMER_OFL,
	input wire logic              EXT_COUNT_IN,
	input wire logic              IRQ
);
	// ----------------------------------------------------------------
	// sequences and assertions
	// ----------------------------------------------------------------
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	sequence s_req;
		READ || WRITE;
	endsequence
	sequence s_wdone(logic [7:0] a);
		WRITE && !WAITREQUEST && ADDRESS == a && BYTEENABLE == 4'hF;
	endsequence
	a_wait_first: assert property (
		!$past(READ || WRITE) && (READ || WRITE) |-> WAITREQUEST)
		else $error("no wait cycle on a new request");
	a_one_wait: assert property (s_req ##0 WAITREQUEST |=> !WAITREQUEST)
		else $error("answer not after one wait cycle");
	a_unmapped_zero: assert property (
		READ && !WAITREQUEST && ADDRESS inside {[8'h20:8'h3C]} |-> READDATA == 32'h0)
		else $error("unmapped read not zero");
	a_irq_masked: assert property (
		s_wdone(OFS_IRQ_EN) ##0 WRITEDATA == 32'h0 |=> !IRQ)
		else $error("irq high with all enables off");
	a_oe_drive: assert property (
		s_wdone(8'h54) ##0 WRITEDATA[8:0] == 9'h111 |-> ##[1:2] CC_OE[5])
		else $error("compare pin not driven");
	a_oe_capture: assert property (
		s_wdone(8'h4C) ##0 !WRITEDATA[0] |-> ##[1:2] !CC_OE[3])
		else $error("capture pin still driven");
	a_oe_quiet: assert property (
		!$past(WRITE && !WAITREQUEST) && !$past(WRITE && !WAITREQUEST, 2)
		|-> $stable(CC_OE))
		else $error("enable changed without a write");
	a_pin_owned: assert property (
		((CC_OUT ^ $past(CC_OUT)) & ~CC_OE & ~$past(CC_OE)) == 16'h0)
		else $error("undriven pin level changed");
	a_reset_quiet: assert property (
		!$past(ARST_N) |-> CC_OUT == 16'h0 && CC_OE == 16'h0 && !IRQ)
		else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ==== test/capture_compare_unit_tb.sv ====
// testbench: register tasks and scenarios for the capture/compare unit
// assumes pin_partner on the pins and the checker bound below
`timescale 1ns/10ps
`default_nettype none
module capture_compare_unit_tb
	import capture_compare_pkg::*;
;
	logic              CLK = 1'b0;
	logic              ARST_N;
	logic [7:0]        ADDRESS;
	logic              READ;
	logic              WRITE;
	logic [31:0]       WRITEDATA;
	logic [3:0]        BYTEENABLE;
	logic [31:0]       READDATA;
	logic              WAITREQUEST;
	logic [NUM_CH-1:0] CC_IN;
	logic [NUM_CH-1:0] CC_OUT;
	logic [NUM_CH-1:0] CC_OE;
	logic              SIXTH_TIMER_OFL;
	logic              EXT_COUNT_IN;
	logic              IRQ;
	logic [31:0]       q;
	int                bad_count = 0;
	int                checks = 0;
	// ch4..7 modes 0..3, ch10 single toggle, ch0 double toggle, ch8 its partner
	int                ch [7] = '{4, 5, 6, 7, 10, 0, 8};
	logic [15:0]       cfg [7] = '{16'h101, 16'h111, 16'h121, 16'h131, 16'h151, 16'h191, 16'h101};
	logic [15:0]       cv [7] = '{16'hFFD0, 16'hFFD0, 16'hFFD0, 16'hFFD0, 16'hFFD0, 16'hFFCC, 16'hFFF0};

	always #20 CLK = ~CLK;

	capture_compare_unit capture_compare_unit_inst (
		.CLK(CLK), .ARST_N(ARST_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
		.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .CC_IN(CC_IN), .CC_OUT(CC_OUT), .CC_OE(CC_OE),
		.SIXTH_TIMER_OFL(SIXTH_TIMER_OFL), .EXT_COUNT_IN(EXT_COUNT_IN), .IRQ(IRQ));
	pin_partner pin_partner_inst (.CLK(CLK), .CC_OUT(CC_OUT), .CC_OE(CC_OE), .CC_IN(CC_IN),
		.SIXTH_TIMER_OFL(SIXTH_TIMER_OFL), .EXT_COUNT_IN(EXT_COUNT_IN));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] e, input string what);
		checks++;
		if (seen !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		ADDRESS <= a;
		WRITEDATA <= d;
		WRITE <= w;
		READ <= !w;
		n = 0;
		// look at the answer mid-cycle, where it has settled
		do begin
			@(negedge CLK);
			n++;
		end while (WAITREQUEST !== 1'b0 && n < 50);
		q = READDATA;
		@(posedge CLK);
		WRITE <= 1'b0;
		READ <= 1'b0;
		if (WAITREQUEST !== 1'b0) begin
			bad_count++;
			finish_test();
		end
		@(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h0);
		chk(q, e, what);
	endtask
	task automatic pass(input logic [15:0] v);
		wr(OFS_TA_COUNT, {16'h0, v});
		repeat (16) @(posedge CLK);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		ARST_N = 1'b0;
		READ = 1'b0;
		WRITE = 1'b0;
		ADDRESS = 8'h0;
		WRITEDATA = 32'h0;
		BYTEENABLE = 4'hF;
		repeat (3) @(posedge CLK);
		ARST_N <= 1'b1;
		rd(OFS_CTRL, 32'h0, "ctrl");
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0, "unmapped");
		wr(OFS_IRQ_STATUS, 32'hFFFF_FFFF);
		rd(OFS_IRQ_STATUS, 32'h0, "status");
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CTRL, k ? 32'h602 : 32'h502);
			wr(OFS_TB_COUNT, 32'h0);
			pin_partner_inst.pulse(k[0], 5);
			rd(OFS_TB_COUNT, 32'h5, "count");
		end
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_EN, 32'h8);
		for (int k = 1; k < 4; k++) begin
			wr(8'h4C, 32'h102 | (k << 2));
			wr(8'h8C, 32'h0);
			wr(OFS_IRQ_CLEAR, 32'h3_FFFF);
			wr(OFS_TB_COUNT, 32'h100 + k);
			pin_partner_inst.set_pin(3, 1'b1);
			wr(OFS_TB_COUNT, 32'h200 + k);
			pin_partner_inst.set_pin(3, 1'b0);
			rd(8'h8C, (k == 1) ? 32'h101 : 32'h200 + k, "capture");
			chk(IRQ, 32'h1, "capture irq");
		end
		wr(OFS_IRQ_EN, 32'h0);
		chk(IRQ, 32'h0, "masked irq");
		wr(OFS_TA_RELOAD, 32'h1000);
		for (int i = 0; i < 7; i++) begin
			wr(8'(8'h40 + 4 * ch[i]), {16'h0, cfg[i]});
			wr(8'(8'h80 + 4 * ch[i]), {16'h0, cv[i]});
		end
		wr(OFS_CTRL, 32'h1);
		pass(16'hFFC8);
		chk(CC_OUT, 32'h4A1, "pins first");
		wr(OFS_IRQ_EN, 32'h40);
		chk(IRQ, 32'h1, "once irq");
		wr(OFS_IRQ_CLEAR, 32'h3_FFFF);
		pass(16'hFFC8);
		chk(IRQ, 32'h0, "once again");
		wr(OFS_IRQ_EN, 32'h10);
		chk(IRQ, 32'h1, "multi irq");
		chk(CC_OUT, 32'h480, "pins second");
		pass(16'hFFE8);
		chk({CC_OE[8], CC_OUT}, 32'h481, "shared pin");
		repeat (20) @(posedge CLK);
		chk(CC_OUT, 32'h401, "overflow");
		bus(1'b0, OFS_TA_COUNT, 32'h0);
		chk(q[31:8], 32'h10, "reload");
		wr(OFS_CTRL, 32'h5);
		wr(OFS_IRQ_CLEAR, 32'h3_FFFF);
		pass(16'hFFC8);
		repeat (14) @(posedge CLK);
		chk(IRQ, 32'h0, "stagger early");
		repeat (50) @(posedge CLK);
		chk(IRQ, 32'h1, "stagger late");
		wr(OFS_CTRL, 32'h0);
		finish_test();
	end
endmodule

bind capture_compare_unit capture_compare_monitor capture_compare_monitor_inst (
	.CLK(CLK), .ARST_N(ARST_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
	.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
	.WAITREQUEST(WAITREQUEST), .CC_IN(CC_IN), .CC_OUT(CC_OUT), .CC_OE(CC_OE),
	.SIXTH_TIMER_OFL(SIXTH_TIMER_OFL), .EXT_COUNT_IN(EXT_COUNT_IN), .IRQ(IRQ));
`default_nettype wire

// ==== test/pin_partner.sv ====
// far-side model: channel pin levels, count input, sixth-timer pulses
// assumes the unit's clock; its tasks are called by the testbench
`timescale 1ns/10ps
`default_nettype none
module pin_partner
	import capture_compare_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic [NUM_CH-1:0] CC_OUT,
	input  wire logic [NUM_CH-1:0] CC_OE,
	output logic [NUM_CH-1:0]      CC_IN,
	output logic                   SIXTH_TIMER_OFL,
	output logic                   EXT_COUNT_IN
);
	logic [NUM_CH-1:0] drv = 16'h0;
	// pin level: the unit on driven pins, the model elsewhere
	assign CC_IN = (CC_OUT & CC_OE) | (drv & ~CC_OE);
	initial begin
		SIXTH_TIMER_OFL = 1'b0;
		EXT_COUNT_IN = 1'b0;
	end
	// one pin change, then time for the capture to land
	task automatic set_pin(input int c, input logic v);
		@(posedge CLK);
		drv[c] <= v;
		repeat (6) @(posedge CLK);
	endtask
	// n pulses on the count input or the sixth-timer line
	task automatic pulse(input logic ext, input int n);
		repeat (n) begin
			@(posedge CLK);
			EXT_COUNT_IN <= ext;
			SIXTH_TIMER_OFL <= !ext;
			@(posedge CLK);
			SIXTH_TIMER_OFL <= 1'b0;
			// the count pin is slow: hold it past the synchroniser
			repeat (3) @(posedge CLK);
			EXT_COUNT_IN <= 1'b0;
			repeat (4) @(posedge CLK);
		end
	endtask
endmodule
`default_nettype wire
